// [rtl/elevc_top.sv]
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module elevc_top
    import elevc_pkg::*;
#(
    parameter int NUM_LINES = NUM_LINES_DEF,
    parameter int NUM_EXT   = NUM_EXT_DEF,
    parameter int NUM_PINS  = NUM_PINS_DEF
) (
    input  wire logic                      CLK,
    input  wire logic                      RST_N,
    input  wire elevc_req_s                REG_REQ,
    output logic [DATA_W-1:0]              REG_RDATA,
    input  wire logic [NUM_PINS-1:0]       PIN_IN,
    input  wire logic [NUM_LINES-NUM_EXT-1:0] PERIPH_IN,
    output logic [NUM_LINES-1:0]           IRQ_REQ,
    output logic [NUM_LINES-1:0]           EVT_PULSE
);
    localparam int SRC_W     = $clog2(NUM_PINS);
    localparam int SRC_WORDS = (NUM_EXT + SRC_PER_WORD - 1) / SRC_PER_WORD;

    // refuse sizes the register layout cannot hold
    if (NUM_LINES > DATA_W || NUM_EXT > NUM_LINES || SRC_W > SRC_FIELD_W || NUM_PINS < 2) begin : g_bad_size
        $error("elevc_top: unsupported line or pin count");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic [NUM_LINES-1:0]   int_mask_q, int_mask_d;
    logic [NUM_LINES-1:0]   evt_mask_q, evt_mask_d;
    logic [NUM_LINES-1:0]   rise_sel_q, rise_sel_d;
    logic [NUM_LINES-1:0]   fall_sel_q, fall_sel_d;
    logic [NUM_LINES-1:0]   pend_q,     pend_d;
    logic [NUM_LINES-1:0]   sw_trig_q,  sw_trig_d;
    logic [SRC_FIELD_W-1:0] src_sel_q [NUM_EXT];
    logic [SRC_FIELD_W-1:0] src_sel_d [NUM_EXT];
    logic [DATA_W-1:0]      rdata_q,    rdata_d;
    logic [NUM_LINES-1:0]   irq_q,      irq_d;
    logic [NUM_LINES-1:0]   evt_q,      evt_d;
    logic [NUM_LINES-1:0]   line_raw;
    logic [NUM_LINES-1:0]   rise_det;
    logic [NUM_LINES-1:0]   fall_det;
    logic [NUM_LINES-1:0]   trig;
    logic [NUM_LINES-1:0]   wdat_l;

    assign wdat_l = REG_REQ.wdata[NUM_LINES-1:0];

    ////////////////////////////////////////////////////////////////////////
    // pin selector: one pin per external line; a select change may glitch
    // the line, so software should mask the line while changing its source
    generate
        for (genvar e = 0; e < NUM_EXT; e++) begin : g_src
            logic [SRC_W-1:0] idx;
            assign idx = src_sel_q[e][SRC_W-1:0];
            assign line_raw[e] = (int'(idx) < NUM_PINS) ? PIN_IN[idx] : 1'b0;
        end
        for (genvar p = NUM_EXT; p < NUM_LINES; p++) begin : g_periph
            assign line_raw[p] = PERIPH_IN[p-NUM_EXT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // one asynchronous capture cell per line
    generate
        for (genvar l = 0; l < NUM_LINES; l++) begin : g_cell
            elevc_edge_cell u_cell (
                .clk        (CLK),
                .rst_n      (RST_N),
                .line_in    (line_raw[l]),
                .rise_pulse (rise_det[l]),
                .fall_pulse (fall_det[l])
            );
        end
    endgenerate

    // edge matched against the chosen setting, or a software trigger
    assign trig = (rise_det & rise_sel_q) | (fall_det & fall_sel_q) | sw_trig_q;

    ////////////////////////////////////////////////////////////////////////
    // register writes, pending store and outputs
    always_comb begin
        int_mask_d = int_mask_q;
        evt_mask_d = evt_mask_q;
        rise_sel_d = rise_sel_q;
        fall_sel_d = fall_sel_q;
        sw_trig_d  = '0;
        for (int e = 0; e < NUM_EXT; e++) begin
            src_sel_d[e] = src_sel_q[e];
        end
        if (REG_REQ.wr) begin
            if (hit(REG_REQ.addr, OFF_INT_MASK)) int_mask_d = wdat_l;
            if (hit(REG_REQ.addr, OFF_EVT_MASK)) evt_mask_d = wdat_l;
            if (hit(REG_REQ.addr, OFF_RISE_SEL)) rise_sel_d = wdat_l;
            if (hit(REG_REQ.addr, OFF_FALL_SEL)) fall_sel_d = wdat_l;
            if (hit(REG_REQ.addr, OFF_SW_TRIG))  sw_trig_d  = wdat_l;
            for (int e = 0; e < NUM_EXT; e++) begin
                if (hit(REG_REQ.addr, OFF_SRC_SEL0 + ADDR_W'((e / SRC_PER_WORD) << SRC_WORD_SHIFT))) begin
                    src_sel_d[e] = REG_REQ.wdata[(e % SRC_PER_WORD) * SRC_FIELD_W +: SRC_FIELD_W];
                end
            end
        end
        // new request wins over a same-cycle clear; reads never clear
        pend_d = pend_q;
        if (REG_REQ.wr && hit(REG_REQ.addr, OFF_PENDING)) begin
            pend_d = pend_q & ~wdat_l;
        end
        pend_d = pend_d | (trig & int_mask_q);
        irq_d  = pend_d;
        evt_d  = trig & evt_mask_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the read strobe
    always_comb begin
        rdata_d = '0;
        if (REG_REQ.rd) begin
            if (hit(REG_REQ.addr, OFF_INT_MASK)) rdata_d[NUM_LINES-1:0] = int_mask_q;
            if (hit(REG_REQ.addr, OFF_EVT_MASK)) rdata_d[NUM_LINES-1:0] = evt_mask_q;
            if (hit(REG_REQ.addr, OFF_RISE_SEL)) rdata_d[NUM_LINES-1:0] = rise_sel_q;
            if (hit(REG_REQ.addr, OFF_FALL_SEL)) rdata_d[NUM_LINES-1:0] = fall_sel_q;
            if (hit(REG_REQ.addr, OFF_PENDING))  rdata_d[NUM_LINES-1:0] = pend_q;
            for (int e = 0; e < NUM_EXT; e++) begin
                if (hit(REG_REQ.addr, OFF_SRC_SEL0 + ADDR_W'((e / SRC_PER_WORD) << SRC_WORD_SHIFT))) begin
                    rdata_d[(e % SRC_PER_WORD) * SRC_FIELD_W +: SRC_FIELD_W] = src_sel_q[e];
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            int_mask_q <= RST_MASK[NUM_LINES-1:0];
            evt_mask_q <= RST_MASK[NUM_LINES-1:0];
            rise_sel_q <= RST_MASK[NUM_LINES-1:0];
            fall_sel_q <= RST_MASK[NUM_LINES-1:0];
            sw_trig_q  <= RST_MASK[NUM_LINES-1:0];
            pend_q     <= RST_MASK[NUM_LINES-1:0];
            irq_q      <= RST_MASK[NUM_LINES-1:0];
            evt_q      <= RST_MASK[NUM_LINES-1:0];
            rdata_q    <= RST_MASK;
            for (int e = 0; e < NUM_EXT; e++) begin
                src_sel_q[e] <= RST_SRC;
            end
        end else begin
            int_mask_q <= int_mask_d;
            evt_mask_q <= evt_mask_d;
            rise_sel_q <= rise_sel_d;
            fall_sel_q <= fall_sel_d;
            sw_trig_q  <= sw_trig_d;
            pend_q     <= pend_d;
            irq_q      <= irq_d;
            evt_q      <= evt_d;
            rdata_q    <= rdata_d;
            for (int e = 0; e < NUM_EXT; e++) begin
                src_sel_q[e] <= src_sel_d[e];
            end
        end
    end

    assign REG_RDATA = rdata_q;
    assign IRQ_REQ   = irq_q;
    assign EVT_PULSE = evt_q;

    // OFF_WORD_STEP documents the spacing of the selector words
    if (OFF_WORD_STEP != ADDR_W'(1 << SRC_WORD_SHIFT)) begin : g_bad_step
        $error("elevc_top: selector word step mismatch");
    end
endmodule : elevc_top // elevc_top
`default_nettype wire

// [rtl/elevc_pkg.sv]
`default_nettype none
package elevc_pkg;
    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RISE_SEL  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FALL_SEL  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_SW_TRIG   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PENDING   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SRC_SEL0  = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_WORD_STEP = 8'h04;

    // source selector field layout: four 8-bit fields per word
    localparam int SRC_FIELD_W    = 8;
    localparam int SRC_PER_WORD   = 4;
    localparam int SRC_WORD_SHIFT = 2;

    // documented sizes
    localparam int NUM_LINES_DEF = 23;
    localparam int NUM_EXT_DEF   = 16;
    localparam int NUM_PINS_DEF  = 168;

    // reset values
    localparam logic [DATA_W-1:0]      RST_MASK = 32'h0000_0000;
    localparam logic [SRC_FIELD_W-1:0] RST_SRC  = 8'h00;

    // register request carried as one bundle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } elevc_req_s;
endpackage : elevc_pkg
`default_nettype wire

// [rtl/elevc_edge_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module elevc_edge_cell (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic line_in,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    logic rise_tgl_q;
    logic fall_tgl_q;
    logic [2:0] rise_sync_q;
    logic [2:0] fall_sync_q;
    logic [2:0] rise_sync_d;
    logic [2:0] fall_sync_d;

    ////////////////////////////////////////////////////////////////////////
    // the line itself clocks these, so a pulse shorter than clk is kept
    always_ff @(posedge line_in or negedge rst_n) begin
        if (!rst_n) begin
            rise_tgl_q <= 1'b0;
        end else begin
            rise_tgl_q <= ~rise_tgl_q;
        end
    end

    always_ff @(negedge line_in or negedge rst_n) begin
        if (!rst_n) begin
            fall_tgl_q <= 1'b0;
        end else begin
            fall_tgl_q <= ~fall_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-flop crossing plus one history stage per toggle
    always_comb begin
        rise_sync_d = {rise_sync_q[1:0], rise_tgl_q};
        fall_sync_d = {fall_sync_q[1:0], fall_tgl_q};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rise_sync_q <= 3'h0;
            fall_sync_q <= 3'h0;
        end else begin
            rise_sync_q <= rise_sync_d;
            fall_sync_q <= fall_sync_d;
        end
    end

    // first stage is never looked at directly
    assign rise_pulse = rise_sync_q[1] ^ rise_sync_q[2];
    assign fall_pulse = fall_sync_q[1] ^ fall_sync_q[2];
endmodule : elevc_edge_cell // elevc_edge_cell
`default_nettype wire

// [verification/elevc_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module elevc_mon
    import elevc_pkg::*;
#(
    parameter int NUM_LINES = 23,
    parameter int NUM_EXT   = 16,
    parameter int NUM_PINS  = 168
) (
    input wire logic                          CLK,
    input wire logic                          RST_N,
    input wire elevc_req_s                    REG_REQ,
    input wire logic [DATA_W-1:0]             REG_RDATA,
    input wire logic [NUM_PINS-1:0]           PIN_IN,
    input wire logic [NUM_LINES-NUM_EXT-1:0]  PERIPH_IN,
    input wire logic [NUM_LINES-1:0]          IRQ_REQ,
    input wire logic [NUM_LINES-1:0]          EVT_PULSE
);
    logic [NUM_LINES-1:0] im_q, em_q, clr_q;
    logic                 rp_q, ri_q, rz_q, rs_q;
    ////////////////////////////////////////////////////////////////////////////
    // shadow masks and last-request flags, so each property sees the old state
    always_ff @(posedge CLK) begin
        clr_q <= (REG_REQ.wr && REG_REQ.addr == OFF_PENDING) ? REG_REQ.wdata[NUM_LINES-1:0] : '0;
        rp_q  <= REG_REQ.rd && REG_REQ.addr == OFF_PENDING;
        ri_q  <= REG_REQ.rd && REG_REQ.addr == OFF_INT_MASK;
        // selector words fill all 32 bits, so they are exempt from the upper-zero check
        rs_q  <= REG_REQ.rd && REG_REQ.addr[1:0] == 2'h0 && REG_REQ.addr >= OFF_SRC_SEL0
                 && REG_REQ.addr <= OFF_SRC_SEL0 + 8'h0c;
        rz_q  <= REG_REQ.rd && (REG_REQ.addr == OFF_SW_TRIG || REG_REQ.addr > OFF_SRC_SEL0 + 8'h0c);
        if (!RST_N) begin
            im_q <= '0;
            em_q <= '0;
        end else if (REG_REQ.wr && REG_REQ.addr == OFF_INT_MASK) begin
            im_q <= REG_REQ.wdata[NUM_LINES-1:0];
        end else if (REG_REQ.wr && REG_REQ.addr == OFF_EVT_MASK) begin
            em_q <= REG_REQ.wdata[NUM_LINES-1:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_rdata_idle: assert property (!$past(REG_REQ.rd) |-> REG_RDATA == '0)
        else $error("read data not idle");
    a_reset_quiet: assert property ($rose(RST_N) |-> IRQ_REQ == '0 && EVT_PULSE == '0)
        else $error("outputs busy after reset");
    a_clear_only: assert property (($past(IRQ_REQ) & ~IRQ_REQ & ~clr_q) == '0)
        else $error("pending dropped without a one write");
    a_irq_masked: assert property ((IRQ_REQ & ~$past(IRQ_REQ) & ~$past(im_q)) == '0)
        else $error("masked line raised a request");
    a_evt_masked: assert property ((EVT_PULSE & ~$past(em_q)) == '0)
        else $error("masked line raised an event");
    a_pend_read: assert property (rp_q |-> REG_RDATA[NUM_LINES-1:0] == $past(IRQ_REQ))
        else $error("pending read differs");
    a_upper_zero: assert property (!rs_q |-> REG_RDATA[DATA_W-1:NUM_LINES] == '0)
        else $error("unused read bits set");
    a_mask_read: assert property (ri_q |-> REG_RDATA[NUM_LINES-1:0] == $past(im_q))
        else $error("mask readback differs");
    a_read_zero: assert property (rz_q |-> REG_RDATA == '0)
        else $error("trigger or unmapped read not zero");
    c_pend_seen: cover property (rp_q && REG_RDATA != '0);
    c_irq_rise: cover property ($rose(|IRQ_REQ));
    c_evt_seen: cover property (|EVT_PULSE);
    c_sel_read: cover property (rs_q && REG_RDATA != '0);
endmodule // elevc_mon
`default_nettype wire

// [verification/elevc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module elevc_pin_model #(
    parameter int NUM_PINS = 168,
    parameter int NUM_PER  = 7
) (
    output wire logic [NUM_PINS-1:0] pins,
    output wire logic [NUM_PER-1:0]  per
);
    logic [NUM_PINS+NUM_PER-1:0] lv = '0;
    // pins first, then peripheral lines, in one index space
    assign pins = lv[NUM_PINS-1:0];
    assign per  = lv[NUM_PINS+:NUM_PER];
    // single edge, kept clear of the clock edge
    task automatic step(input int i);
        #3 lv[i] = ~lv[i];
    endtask
    // pulse well under one clock period
    task automatic glitch(input int i);
        #2 lv[i] = 1'b1;
        #3 lv[i] = 1'b0;
    endtask
endmodule // elevc_pin_model
`default_nettype wire

// [verification/elevc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module elevc_top_test
    import elevc_pkg::*;
;
    typedef struct {int l; int src; bit rs; bit fs; bit im; bit em; int kind; bit xi; bit xe;} elevc_row_s;
    // kind 0 rising step, 1 falling step, 2 short pulse; xi, xe expected request and event count
    elevc_row_s rows[8] = '{'{0, 5, 1, 0, 1, 0, 0, 1, 0}, '{0, 5, 1, 0, 1, 0, 1, 0, 0},
        '{3, 167, 0, 1, 1, 1, 0, 0, 0}, '{3, 167, 0, 1, 1, 1, 1, 1, 1}, '{15, 100, 1, 1, 0, 1, 2, 0, 1},
        '{16, 168, 1, 0, 1, 1, 2, 1, 1}, '{22, 174, 1, 1, 1, 0, 0, 1, 0}, '{22, 174, 1, 1, 0, 0, 1, 0, 0}};
    logic        clk = 1'b0;
    logic        rst_n = 1'b1;
    elevc_req_s  req = '0;
    logic [31:0] rdata;
    logic [22:0] irq, evt;
    wire logic [167:0] pin;
    wire logic [6:0]   per;
    int          fail_count = 0;
    int          comparisons = 0;
    elevc_top uut (.CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .PIN_IN(pin),
        .PERIPH_IN(per), .IRQ_REQ(irq), .EVT_PULSE(evt));
    elevc_pin_model #(.NUM_PINS(168), .NUM_PER(7)) pm (.pins(pin), .per(per));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= {a, d, 2'b10};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= {a, 32'h0, 2'b01};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        elevc_row_s  r;
        logic [31:0] d, one, ex, evc;
        // a real falling edge, so the pin-clocked toggles leave the unknown state
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            one = 32'h1 << r.l;
            // selector first so a moved source cannot fire under new masks
            if (r.l < 16) wr(OFF_SRC_SEL0 + 8'(4 * (r.l / 4)), 32'(r.src) << (8 * (r.l % 4)));
            wr(OFF_INT_MASK, one & {32{r.im}});
            wr(OFF_EVT_MASK, one & {32{r.em}});
            wr(OFF_RISE_SEL, one & {32{r.rs}});
            wr(OFF_FALL_SEL, one & {32{r.fs}});
            if (r.kind == 2) pm.glitch(r.src);
            else pm.step(r.src);
            // count event cycles, so a pulse wider than one cycle shows up
            evc = 32'h0;
            repeat (6) begin
                @(posedge clk);
                #1 evc = evc + 32'(evt[r.l]);
            end
            ex = one & {32{r.xi}};
            chk("irq", 32'(irq), ex);
            chk("event", evc, 32'(r.xe));
            rd(OFF_PENDING, d);
            chk("pending", d, ex);
            wr(OFF_PENDING, 32'h7f_ffff);
        end
        // software trigger; zero writes and reads leave pending alone
        wr(OFF_INT_MASK, 32'h2);
        wr(OFF_SW_TRIG, 32'h2);
        wr(OFF_PENDING, 32'h0);
        rd(OFF_PENDING, d);
        rd(OFF_PENDING, d);
        chk("pending kept", d, 32'h2);
        rd(OFF_SW_TRIG, d);
        chk("trigger read", d, 32'h0);
        rd(8'h3c, d);
        chk("unmapped read", d, 32'h0);
        rd(OFF_SRC_SEL0, d);
        chk("selector read", d, 32'ha700_0000);
        wr(OFF_PENDING, 32'h2);
        #1 chk("irq cleared", 32'(irq), 32'h0);
        wr(OFF_SW_TRIG, 32'h2);
        // reset in mid-run with a request standing
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_PENDING, d);
        chk("pending after reset", d, 32'h0);
        rd(OFF_INT_MASK, d);
        chk("mask after reset", d, 32'h0);
        chk("irq after reset", 32'(irq), 32'h0);
        complete_run();
    end
endmodule // elevc_top_test
bind elevc_top elevc_mon #(.NUM_LINES(NUM_LINES), .NUM_EXT(NUM_EXT), .NUM_PINS(NUM_PINS)) u_mon (
    .CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .PIN_IN(PIN_IN),
    .PERIPH_IN(PERIPH_IN), .IRQ_REQ(IRQ_REQ), .EVT_PULSE(EVT_PULSE));
`default_nettype wire
